// File: impec_pkg.sv
/*
  Package for the interrupt mask and failed PIO capture block.
  Holds register offsets, field positions, reset values and the carrier structs.
  Assumes the PCI target logic has already matched the access to its window.
*/
`default_nettype none

package impec_pkg;

  localparam int unsigned IMPEC_DATA_W = 32;
  localparam int unsigned IMPEC_ADDR_W = 12;

  // Offsets within the memory window.
  localparam logic [11:0] IMPEC_MEM_SET_OFS = 12'h1e8;
  localparam logic [11:0] IMPEC_MEM_CLR_OFS = 12'h1ec;
  localparam logic [11:0] IMPEC_MEM_CAP_OFS = 12'h1f0;

  // Offsets within the I/O window: a base plus a register offset.
  localparam logic [11:0] IMPEC_IO_BASE     = 12'h100;
  localparam logic [11:0] IMPEC_IO_SET_OFS  = 12'h0e8;
  localparam logic [11:0] IMPEC_IO_CLR_OFS  = 12'h0ec;
  localparam logic [11:0] IMPEC_IO_CAP_OFS  = 12'h0f0;

  // Reset values.
  localparam logic [31:0] IMPEC_MASK_RESET  = 32'hffff_ffff;
  localparam logic [31:0] IMPEC_CAP_RESET   = 32'h0000_0000;

  // Field positions of the capture register.
  localparam int unsigned IMPEC_CAP_READ_BIT = 0;
  localparam int unsigned IMPEC_CAP_RSVD_BIT = 1;
  localparam int unsigned IMPEC_CAP_ADDR_LSB = 2;

  // One register access from the PCI target.
  typedef struct packed {
    logic        req;
    logic        is_io;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } impec_reg_req_t;

  // One failed programmed-I/O access.
  typedef struct packed {
    logic        fail;
    logic        read;
    logic [31:0] addr;
  } impec_pio_fail_t;

  // Register selects out of the decoder.
  typedef struct packed {
    logic set;
    logic clr;
    logic cap;
  } impec_sel_t;

endpackage

`default_nettype wire

// File: impec_decode.sv
/*
  Window decoder for the mask views and the capture register.
  Assumes only the low offset bits of an already claimed window are presented.
*/
`timescale 1ns/1ps
`default_nettype none

module impec_decode
  import impec_pkg::*;
(
  // Access
  input  wire logic        req,
  input  wire logic        is_io,
  input  wire logic [11:0] addr,
  // Selects
  output var impec_sel_t   sel
);

  localparam logic [11:0] IO_SET = 12'(IMPEC_IO_BASE + IMPEC_IO_SET_OFS);
  localparam logic [11:0] IO_CLR = 12'(IMPEC_IO_BASE + IMPEC_IO_CLR_OFS);
  localparam logic [11:0] IO_CAP = 12'(IMPEC_IO_BASE + IMPEC_IO_CAP_OFS);

  always_comb
  begin
    sel = '0;
    if (req && !is_io)
    begin
      sel.set = (addr == IMPEC_MEM_SET_OFS);
      sel.clr = (addr == IMPEC_MEM_CLR_OFS);
      sel.cap = (addr == IMPEC_MEM_CAP_OFS);
    end
    else if (req && is_io)
    begin
      sel.set = (addr == IO_SET);
      sel.clr = (addr == IO_CLR);
      sel.cap = (addr == IO_CAP);
    end
  end

endmodule

`default_nettype wire

// File: impec_top.sv
/*
  Interrupt mask with set and clear views, interrupt line drive, and capture
  of the first failed programmed-I/O access.
  Assumes the PCI target presents one access per request pulse, synchronous to
  ref_clk, and that the interrupt status register lives outside this block.
*/
// Operation
// - A mask bit at one keeps the interrupt line from being driven by that source even when its status bit is one.
// - After reset all 32 mask bits read as one.
// - The memory window decodes the mask set view at 1E8h and the clear view at 1ECh.
// - The I/O window decodes the mask set view at 100h+E8h and the clear view at 100h+ECh.
// - A failed PIO access to the device has its PCI address captured, first failure only.
// - While a PIO error flag is raised in the status register the captured address stays frozen.
// - Bit 1 of the capture register always reads zero.
// - Bit 0 of the capture register is one for a failed read and zero for a failed write.
// - The capture register is read-only at 1F0h of the memory window and is zero after reset.
// - The capture register is also read-only in the I/O window at 100h+F0h.
// - The interrupt line is driven whenever any status bit is one with its mask bit zero.
`timescale 1ns/1ps
`default_nettype none

module impec_top
  import impec_pkg::*;
#(
  parameter int unsigned N_SRC       = 32,
  parameter logic [31:0] PIO_ERR_SEL = 32'h0000_fff8
)
(
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  // Register access
  input  wire impec_reg_req_t  reg_req,
  output logic [31:0]          reg_rdata,
  output logic                 reg_rvalid,
  // Interrupt sources and failed accesses
  input  wire logic [31:0]     irq_status,
  input  wire impec_pio_fail_t pio_fail,
  // Open-drain interrupt pin, active low
  output logic                 inta_n_o,
  output logic                 inta_n_oe
);

  if (N_SRC != IMPEC_DATA_W)
  begin : g_bad_width
    $error("impec_top supports exactly 32 interrupt sources");
  end

  impec_sel_t  sel;
  logic [31:0] mask_q;
  logic [31:0] cap_q;
  logic        lock_q;
  logic        lock_free;
  logic        pio_flag;
  logic        pio_flag_q;
  logic        frozen;
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic        drive_q;

  impec_decode u_decode (
    .req   (reg_req.req),
    .is_io (reg_req.is_io),
    .addr  (reg_req.addr),
    .sel   (sel)
  );

  // Mask register: both views act on the same bits; writes to the clear
  // view after a set in the same cycle cannot occur since one access is taken.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      mask_q <= IMPEC_MASK_RESET;
    else if (reg_req.write && sel.set)
      mask_q <= mask_q | reg_req.wdata;
    else if (reg_req.write && sel.clr)
      mask_q <= mask_q & ~reg_req.wdata;
  end

  // Freezing: the status flag may rise a few cycles after the failure, so a
  // local lock bridges that gap and is released only when the flag falls.
  assign pio_flag  = |(irq_status & PIO_ERR_SEL);
  assign lock_free = pio_flag_q && !pio_flag;
  // The lock stops freezing in its release cycle, so a failure that lands on
  // the falling flag is captured rather than lost.
  assign frozen    = (lock_q && !lock_free) || pio_flag;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pio_flag_q <= 1'b0;
    else
      pio_flag_q <= pio_flag;
  end

  // A new failure wins over the release of the lock.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      lock_q <= 1'b0;
    else if (pio_fail.fail && !frozen)
      lock_q <= 1'b1;
    else if (lock_free)
      lock_q <= 1'b0;
  end

  // Capture register: no write path exists, so both views are read-only.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cap_q <= IMPEC_CAP_RESET;
    else if (pio_fail.fail && !frozen)
    begin
      cap_q[31:IMPEC_CAP_ADDR_LSB]  <= pio_fail.addr[31:IMPEC_CAP_ADDR_LSB];
      cap_q[IMPEC_CAP_RSVD_BIT]     <= 1'b0;
      cap_q[IMPEC_CAP_READ_BIT]     <= pio_fail.read;
    end
  end

  // Read path: one cycle after the request; unmapped offsets read zero.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= reg_req.req && !reg_req.write;
      if (reg_req.req && !reg_req.write)
      begin
        if (sel.set || sel.clr)
          rdata_q <= mask_q;
        else if (sel.cap)
          rdata_q <= cap_q;
        else
          rdata_q <= '0;
      end
    end
  end

  // Interrupt drive is registered so the pin comes straight from a flop.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      drive_q <= 1'b0;
    else
      drive_q <= |(irq_status & ~mask_q);
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign inta_n_oe  = drive_q;
  assign inta_n_o   = 1'b0;

  // Checks.
  logic seen_q;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      seen_q <= 1'b0;
    else
      seen_q <= 1'b1;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  chk_mask_blocks_line: assert property ((irq_status & ~mask_q) == '0 |=> !inta_n_oe)
    else $error("interrupt driven although every pending source is masked");
  chk_unmasked_drives: assert property (|(irq_status & ~mask_q) |=> inta_n_oe)
    else $error("unmasked pending source did not drive the interrupt");
  chk_mask_reset_ones: assert property (!seen_q
      |-> mask_q == IMPEC_MASK_RESET && cap_q == IMPEC_CAP_RESET)
    else $error("mask or capture not at reset value after reset");
  chk_set_view_write: assert property (reg_req.req && reg_req.write && sel.set
      |=> mask_q == ($past(mask_q) | $past(reg_req.wdata)))
    else $error("set view write did not set the written bits");
  chk_clr_view_write: assert property (reg_req.req && reg_req.write && sel.clr
      |=> mask_q == ($past(mask_q) & ~$past(reg_req.wdata)))
    else $error("clear view write did not clear the written bits");
  // The decode checks restate the window map apart from the decoder, so a slip in either shows up.
  chk_mem_set_decode: assert property (reg_req.req && !reg_req.is_io
      && reg_req.addr == IMPEC_MEM_SET_OFS |-> sel.set && !sel.clr && !sel.cap)
    else $error("memory set view not decoded");
  chk_mem_clr_decode: assert property (reg_req.req && !reg_req.is_io
      && reg_req.addr == IMPEC_MEM_CLR_OFS |-> sel.clr && !sel.set && !sel.cap)
    else $error("memory clear view not decoded");
  chk_mem_cap_decode: assert property (reg_req.req && !reg_req.is_io
      && reg_req.addr == IMPEC_MEM_CAP_OFS |-> sel.cap && !sel.set && !sel.clr)
    else $error("memory capture register not decoded");
  chk_io_set_decode: assert property (reg_req.req && reg_req.is_io
      && reg_req.addr == (IMPEC_IO_BASE + IMPEC_IO_SET_OFS) |-> sel.set && !sel.clr && !sel.cap)
    else $error("I/O set view not decoded");
  chk_io_clr_decode: assert property (reg_req.req && reg_req.is_io
      && reg_req.addr == (IMPEC_IO_BASE + IMPEC_IO_CLR_OFS) |-> sel.clr && !sel.set && !sel.cap)
    else $error("I/O clear view not decoded");
  chk_io_cap_decode: assert property (reg_req.req && reg_req.is_io
      && reg_req.addr == (IMPEC_IO_BASE + IMPEC_IO_CAP_OFS) |-> sel.cap && !sel.set && !sel.clr)
    else $error("I/O capture register not decoded");
  chk_first_capture: assert property (pio_fail.fail && !frozen
      |=> cap_q[31:2] == $past(pio_fail.addr[31:2]) && cap_q[0] == $past(pio_fail.read))
    else $error("first failed access not captured");
  chk_capture_frozen: assert property (frozen |=> $stable(cap_q))
    else $error("capture changed while frozen");
  chk_cap_read_back: assert property (reg_req.req && !reg_req.write && sel.cap
      |=> reg_rvalid && reg_rdata == $past(cap_q) && !reg_rdata[1])
    else $error("capture read returned wrong data");
  chk_cap_readonly: assert property (reg_req.req && reg_req.write && sel.cap && !pio_fail.fail
      |=> $stable(cap_q) && $stable(mask_q))
    else $error("write to capture register changed state");

  cov_masked_pending: cover property (|(irq_status & mask_q) && (irq_status & ~mask_q) == '0);
  cov_capture_taken:  cover property (pio_fail.fail && !frozen);
  cov_second_failure: cover property (pio_fail.fail && frozen);
  cov_io_set_write:   cover property (reg_req.req && reg_req.write && reg_req.is_io && sel.set);
  cov_flag_release:   cover property (lock_q && lock_free);

endmodule

`default_nettype wire

// File: impec_host.sv
/*
  Host model: issues register cycles and reports failed PIO accesses.
  Assumes one ref_clk domain; requests change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module impec_host
  import impec_pkg::*;
(
  // Clock
  input  wire logic        ref_clk,
  // Register access
  output var impec_reg_req_t reg_req,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rvalid,
  // Failed accesses
  output var impec_pio_fail_t pio_fail
);
  initial
  begin
    reg_req  = '0;
    pio_fail = '0;
  end

  // Released data is inverted so a stale value never passes for a fresh one.
  task automatic access(input logic io, input logic wr, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    reg_req <= '{1'b1, io, wr, a, d};
    @(posedge ref_clk);
    reg_req <= '{1'b0, io, wr, a, ~d};
    #1;
    q = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
  endtask

  task automatic fail(input logic rd, input logic [31:0] a);
    @(posedge ref_clk);
    pio_fail <= '{1'b1, rd, a};
    @(posedge ref_clk);
    pio_fail <= '{1'b0, rd, ~a};
  endtask
endmodule

`default_nettype wire

// File: irq_mask_pio_error_capture_tb.sv
/*
  Self-checking bench for the interrupt mask and failed PIO capture block.
  Assumes impec_host drives the register and failure ports.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_mask_pio_error_capture_tb;
  import impec_pkg::*;

  logic            ref_clk    = 1'b0;
  logic            rstn       = 1'b0;
  logic [31:0]     irq_status = '0;
  impec_reg_req_t  reg_req;
  impec_pio_fail_t pio_fail;
  logic [31:0]     reg_rdata;
  logic            reg_rvalid;
  logic            inta_n_o;
  logic            inta_n_oe;
  logic [31:0]     q;
  int              bad_count  = 0;
  int              n_compared = 0;

  always #5 ref_clk = ~ref_clk;

  impec_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .irq_status(irq_status), .pio_fail(pio_fail),
    .inta_n_o(inta_n_o), .inta_n_oe(inta_n_oe));

  impec_host i_host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pio_fail(pio_fail));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic io, input logic [11:0] a);
    i_host.access(io, 1'b0, a, 32'h0000_0000, q);
  endtask

  task automatic wr(input logic io, input logic [11:0] a, input logic [31:0] d);
    i_host.access(io, 1'b1, a, d, q);
  endtask

  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic test_reset;
    rd(1'b0, IMPEC_MEM_SET_OFS);
    check(q, 32'hffff_ffff);
    rd(1'b0, IMPEC_MEM_CLR_OFS);
    check(q, 32'hffff_ffff);
    rd(1'b0, IMPEC_MEM_CAP_OFS);
    check(q, 32'h0000_0000);
    $display("test_reset done");
  endtask

  task automatic test_views;
    logic [11:0] s;
    logic [11:0] c;
    for (int io = 0; io < 2; io++)
    begin
      s = io ? IMPEC_IO_BASE + IMPEC_IO_SET_OFS : IMPEC_MEM_SET_OFS;
      c = io ? IMPEC_IO_BASE + IMPEC_IO_CLR_OFS : IMPEC_MEM_CLR_OFS;
      wr(io[0], c, 32'h0000_00f0);
      rd(io[0], s);
      check(q, 32'hffff_ff0f);
      wr(io[0], s, 32'h0000_0030);
      rd(io[0], c);
      check(q, 32'hffff_ff3f);
      wr(io[0], s, 32'hffff_ffff);
    end
    rd(1'b0, 12'h1f4);
    check(q, 32'h0000_0000);
    $display("test_views done");
  endtask

  task automatic test_irq;
    @(posedge ref_clk);
    irq_status <= 32'h8000_0001;
    settle;
    check({31'h0, inta_n_oe}, 32'h0);
    wr(1'b0, IMPEC_MEM_CLR_OFS, 32'h0000_0002);
    settle;
    check({31'h0, inta_n_oe}, 32'h0);
    wr(1'b1, IMPEC_IO_BASE + IMPEC_IO_CLR_OFS, 32'h8000_0000);
    settle;
    check({31'h0, inta_n_oe}, 32'h1);
    check({31'h0, inta_n_o}, 32'h0);
    wr(1'b0, IMPEC_MEM_SET_OFS, 32'hffff_ffff);
    settle;
    check({31'h0, inta_n_oe}, 32'h0);
    @(posedge ref_clk);
    irq_status <= 32'h0000_0000;
    $display("test_irq done");
  endtask

  task automatic test_capture;
    i_host.fail(1'b1, 32'h0000_1237);
    rd(1'b0, IMPEC_MEM_CAP_OFS);
    check(q, 32'h0000_1235);
    i_host.fail(1'b0, 32'habcd_0008);
    wr(1'b0, IMPEC_MEM_CAP_OFS, 32'hffff_ffff);
    wr(1'b1, IMPEC_IO_BASE + IMPEC_IO_CAP_OFS, 32'hffff_ffff);
    rd(1'b1, IMPEC_IO_BASE + IMPEC_IO_CAP_OFS);
    check(q, 32'h0000_1235);
    // The falling error flag releases the lock; a raised flag alone must still freeze.
    @(posedge ref_clk);
    irq_status <= 32'h0000_0008;
    i_host.fail(1'b1, 32'h5555_5554);
    irq_status <= 32'h0000_0000;
    settle;
    rd(1'b0, IMPEC_MEM_CAP_OFS);
    check(q, 32'h0000_1235);
    @(posedge ref_clk);
    irq_status <= 32'h0000_4000;
    i_host.fail(1'b1, 32'h5555_5554);
    rd(1'b0, IMPEC_MEM_CAP_OFS);
    check(q, 32'h0000_1235);
    @(posedge ref_clk);
    irq_status <= 32'h0000_0000;
    settle;
    i_host.fail(1'b0, 32'habcd_000b);
    rd(1'b0, IMPEC_MEM_CAP_OFS);
    check(q, 32'habcd_0008);
    $display("test_capture done");
  endtask

  task automatic test_reset_again;
    wr(1'b1, IMPEC_IO_BASE + IMPEC_IO_CLR_OFS, 32'h0f0f_0f0f);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(1'b1, IMPEC_IO_BASE + IMPEC_IO_SET_OFS);
    check(q, 32'hffff_ffff);
    rd(1'b1, IMPEC_IO_BASE + IMPEC_IO_CAP_OFS);
    check(q, 32'h0000_0000);
    i_host.fail(1'b1, 32'h0000_0040);
    rd(1'b0, IMPEC_MEM_CAP_OFS);
    check(q, 32'h0000_0041);
    $display("test_reset_again done");
  endtask

  initial
  begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    test_reset;
    test_views;
    test_irq;
    test_capture;
    test_reset_again;
    stop_test;
  end

  initial
  begin
    #20000;
    bad_count++;
    stop_test;
  end
endmodule

`default_nettype wire
